// ### core/rc_oscillator_self_tune.sv
// Overview of operation
// RULE_01 - enable bit 15 runs loop, clear idles
// RULE_02 - source bit 0 selects secondary crystal reference
// RULE_03 - corrections only through trim bits 5:0
// RULE_04 - hold rc near 8 MHz against reference
// RULE_05 - measure and adjust continuously while enabled
// RULE_06 - software trim writes ignored while active
// RULE_07 - drift beyond 0.2% loses lock
// RULE_08 - deviation beyond 1.5% flags out of range
// RULE_09 - lock in bit 11, range in 9
// RULE_10 - bits 10 and 8 pick irq polarity
// RULE_11 - software reads both status bits after irq
// RULE_12 - software ignores polarity bits when disabled
// RULE_13 - software keeps secondary crystal enabled when selected
// RULE_14 - irq flag sets on rise, held till cleared
// RULE_15 - source bit 1 selects alternate on-chip reference
`timescale 1ns/1ps
`default_nettype none
`include "selftrim_defines.svh"

module rc_oscillator_self_tune (
  input wire logic clk,
  input wire logic rst,
  input wire logic rc_osc_in,
  input wire logic ref_secondary_in,
  input wire logic ref_alternate_in,
  input wire logic trim_wr,
  input wire logic [15:0] trim_wdata,
  input wire logic irq_clear,
  output logic [15:0] trim_reg,
  output logic [5:0] trim_value,
  output logic selftrim_irq_flag,
  output logic loop_active
);

  // absolute value of a signed deviation
  function automatic logic [16:0] abs_dev(input logic signed [16:0] d);
    abs_dev = d[16] ? 17'(-d) : d;
  endfunction

  selftrim_if meas_if ();

  selftrim_pkg::state_t state;
  selftrim_pkg::state_t next_state;

  logic selftrim_enable;
  logic reference_source_select;
  logic lock_irq_polarity;
  logic range_irq_polarity;
  logic lock_status;
  logic range_fault_status;
  selftrim_pkg::trim_t trim;
  logic irq_cond_prev;
  logic irq_flag;
  wire [15:0] reset_image = `TRIM_REG_RESET;

  ref_edge_counter meter (
    .clk(clk),
    .rst(rst),
    .rc_osc_in(rc_osc_in),
    .ref_secondary_in(ref_secondary_in),
    .ref_alternate_in(ref_alternate_in),
    .meas(meas_if.meter)
  );

  // measurement runs only while enabled and the source is steady
  logic source_seen;
  wire source_changed = (source_seen != reference_source_select);
  assign meas_if.start = (state != selftrim_pkg::ST_IDLE) & ~source_changed; // RULE_01
  assign meas_if.source_sel = reference_source_select; // RULE_02 RULE_15

  always_ff @(posedge clk) begin
    if (rst) begin
      source_seen <= 1'b0;
    end else begin
      source_seen <= reference_source_select;
    end
  end

  // deviation of the measured count from nominal
  wire [16:0] nominal = 17'(`NOMINAL_COUNT);
  wire signed [16:0] deviation = $signed({1'b0, meas_if.count}) - $signed(nominal); // RULE_04
  wire [16:0] dev_mag = abs_dev(deviation);
  wire locked_now = (dev_mag <= 17'(`LOCK_TOL_COUNT)); // RULE_07
  wire out_of_range_now = (dev_mag > 17'(`RANGE_TOL_COUNT)); // RULE_08
  wire too_fast = ~deviation[16] & (dev_mag > 17'(`TRIM_DEADBAND));
  wire too_slow = deviation[16] & (dev_mag > 17'(`TRIM_DEADBAND));
  wire at_max = (trim == `TRIM_MAX);
  wire at_min = (trim == `TRIM_MIN);

  // next trim step, saturating in signed six-bit range
  selftrim_pkg::trim_t trim_step;
  assign trim_step = (too_fast && !at_min) ? trim - 6'h01 :
                     (too_slow && !at_max) ? trim + 6'h01 : trim; // RULE_03

  always_comb begin
    next_state = state;
    unique case (state)
      selftrim_pkg::ST_IDLE: begin
        if (selftrim_enable) begin
          next_state = selftrim_pkg::ST_MEASURE;
        end
      end
      selftrim_pkg::ST_MEASURE: begin
        if (!selftrim_enable) begin
          next_state = selftrim_pkg::ST_IDLE;
        end else if (meas_if.done) begin
          next_state = selftrim_pkg::ST_ADJUST;
        end
      end
      selftrim_pkg::ST_ADJUST: begin
        next_state = selftrim_enable ? selftrim_pkg::ST_MEASURE : selftrim_pkg::ST_IDLE; // RULE_05
      end
      default: begin
        next_state = selftrim_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= selftrim_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // control bits written by software
  always_ff @(posedge clk) begin
    if (rst) begin
      selftrim_enable <= reset_image[`BIT_ENABLE];
      reference_source_select <= 1'b0;
      lock_irq_polarity <= 1'b0;
      range_irq_polarity <= 1'b0;
    end else if (trim_wr) begin
      selftrim_enable <= trim_wdata[`BIT_ENABLE]; // RULE_01
      reference_source_select <= trim_wdata[`BIT_SOURCE];
      lock_irq_polarity <= trim_wdata[`BIT_LOCK_POL];
      range_irq_polarity <= trim_wdata[`BIT_RANGE_POL];
    end
  end

  wire adjust_now = (state == selftrim_pkg::ST_ADJUST) & selftrim_enable;

  // trim field: hardware owns it while the loop is active
  always_ff @(posedge clk) begin
    if (rst) begin
      trim <= 6'h00;
    end else if (adjust_now) begin
      trim <= trim_step; // RULE_03 RULE_05
    end else if (trim_wr && !selftrim_enable) begin
      trim <= trim_wdata[`TRIM_MSB:`TRIM_LSB]; // RULE_06
    end
  end

  // status follows each completed measurement
  always_ff @(posedge clk) begin
    if (rst || !selftrim_enable) begin
      lock_status <= 1'b0;
      range_fault_status <= 1'b0;
    end else if (adjust_now) begin
      lock_status <= locked_now; // RULE_09
      range_fault_status <= out_of_range_now; // RULE_09
    end
  end

  // polarity-qualified conditions, edge triggered sticky flag
  wire lock_cond = lock_irq_polarity ? lock_status : ~lock_status; // RULE_10
  wire range_cond = range_irq_polarity ? range_fault_status : ~range_fault_status; // RULE_10
  wire irq_cond = selftrim_enable & (state != selftrim_pkg::ST_IDLE) & (lock_cond | range_cond);
  wire irq_rise = irq_cond & ~irq_cond_prev;

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_cond_prev <= 1'b0;
      irq_flag <= 1'b0;
    end else begin
      irq_cond_prev <= irq_cond;
      if (irq_rise) begin
        irq_flag <= 1'b1; // RULE_14
      end else if (irq_clear) begin
        irq_flag <= 1'b0;
      end
    end
  end

  // register image for software reads
  always_comb begin
    trim_reg = 16'h0000;
    trim_reg[`BIT_ENABLE] = selftrim_enable;
    trim_reg[`BIT_SOURCE] = reference_source_select;
    trim_reg[`BIT_LOCK] = lock_status;
    trim_reg[`BIT_LOCK_POL] = lock_irq_polarity;
    trim_reg[`BIT_RANGE] = range_fault_status;
    trim_reg[`BIT_RANGE_POL] = range_irq_polarity;
    trim_reg[`TRIM_MSB:`TRIM_LSB] = trim;
  end

  assign trim_value = trim;
  assign selftrim_irq_flag = irq_flag;
  assign loop_active = (state != selftrim_pkg::ST_IDLE);

endmodule

`default_nettype wire

// ### shared/selftrim_defines.svh
`ifndef SELFTRIM_DEFINES_SVH
`define SELFTRIM_DEFINES_SVH

// oscillator trim register layout and reset value
`define TRIM_REG_RESET 16'h0000
`define BIT_ENABLE 15
`define BIT_SOURCE 12
`define BIT_LOCK 11
`define BIT_LOCK_POL 10
`define BIT_RANGE 9
`define BIT_RANGE_POL 8
`define TRIM_MSB 5
`define TRIM_LSB 0
`define TRIM_MAX 6'h1f
`define TRIM_MIN 6'h20

// frequencies and measurement windows
`define RC_NOMINAL_HZ 8000000
`define SECONDARY_REF_HZ 32768
`define SECONDARY_WINDOW 64
`define ALTERNATE_REF_HZ 2048000
`define ALTERNATE_WINDOW (`ALTERNATE_REF_HZ * `SECONDARY_WINDOW / `SECONDARY_REF_HZ)

// expected rc edges per window and tolerances in counts
`define NOMINAL_COUNT (`RC_NOMINAL_HZ / `SECONDARY_REF_HZ * `SECONDARY_WINDOW + \
  (`RC_NOMINAL_HZ % `SECONDARY_REF_HZ) * `SECONDARY_WINDOW / `SECONDARY_REF_HZ)
`define LOCK_TOL_PERMILLE 2
`define RANGE_TOL_PERMILLE 15
`define LOCK_TOL_COUNT (`NOMINAL_COUNT * `LOCK_TOL_PERMILLE / 1000)
`define RANGE_TOL_COUNT (`NOMINAL_COUNT * `RANGE_TOL_PERMILLE / 1000)
`define TRIM_DEADBAND 8

`endif

// ### shared/selftrim_pkg.sv
package selftrim_pkg;

  typedef logic [15:0] count_t;
  typedef logic [12:0] window_t;
  typedef logic [5:0] trim_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MEASURE = 2'b01,
    ST_ADJUST = 2'b10
  } state_t;

endpackage

// ### shared/selftrim_if.sv
`timescale 1ns/1ps
`default_nettype none

interface selftrim_if;
  logic start;
  logic source_sel;
  logic done;
  selftrim_pkg::count_t count;

  modport meter (
    input start,
    input source_sel,
    output done,
    output count
  );

  modport ctrl (
    output start,
    output source_sel,
    input done,
    input count
  );
endinterface

`default_nettype wire

// ### core/ref_edge_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "selftrim_defines.svh"

// counts rc oscillator edges across a fixed number of reference periods
module ref_edge_counter (
  input wire logic clk,
  input wire logic rst,
  input wire logic rc_osc_in,
  input wire logic ref_secondary_in,
  input wire logic ref_alternate_in,
  selftrim_if.meter meas
);

  logic rc_prev;
  logic ref_prev;
  logic armed;
  selftrim_pkg::window_t periods;
  selftrim_pkg::count_t edges;
  logic done;
  selftrim_pkg::count_t count;

  wire ref_sel = meas.source_sel ? ref_alternate_in : ref_secondary_in;
  wire ref_rise = ref_sel & ~ref_prev;
  wire rc_rise = rc_osc_in & ~rc_prev;
  wire selftrim_pkg::window_t window_len = meas.source_sel
    ? 13'(`ALTERNATE_WINDOW) : 13'(`SECONDARY_WINDOW);
  wire window_end = armed & ref_rise & (periods == window_len - 13'h0001);
  wire edges_full = (edges == 16'hffff);

  always_ff @(posedge clk) begin
    rc_prev <= rc_osc_in;
    ref_prev <= ref_sel;
    if (rst || !meas.start) begin
      armed <= 1'b0;
      periods <= 13'h0000;
      edges <= 16'h0000;
      done <= 1'b0;
    end else begin
      done <= window_end;
      if (ref_rise) begin
        armed <= 1'b1;
        periods <= window_end ? 13'h0000 : (armed ? periods + 13'h0001 : 13'h0000);
      end
      // edges accumulate over the whole window, cleared when a window opens and while start is low
      if (ref_rise && (window_end || !armed)) begin
        edges <= 16'h0000;
      end else if (armed && rc_rise && !edges_full) begin
        edges <= edges + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count <= 16'h0000;
    end else if (window_end) begin
      count <= edges;
    end
  end

  assign meas.done = done;
  assign meas.count = count;

endmodule

`default_nettype wire

// ### test/osc_model.sv
`timescale 1ns/1ps
`default_nettype none
// rc oscillator and both references; rc and secondary scaled together so one window fits a short run, alternate at 64x secondary
module osc_model (
  output logic rc_osc_in,
  output logic ref_secondary_in,
  output logic ref_alternate_in
);
  localparam realtime RC_HALF = 15.0;
  localparam realtime SEC_HALF = 3662.109375;
  localparam realtime ALT_HALF = 57.220458984375;
  initial begin
    rc_osc_in = 0;
    #1.5;
    forever #(RC_HALF) rc_osc_in = ~rc_osc_in;
  end
  initial begin
    ref_secondary_in = 0;
    forever #(SEC_HALF) ref_secondary_in = ~ref_secondary_in;
  end
  initial begin
    ref_alternate_in = 0;
    forever #(ALT_HALF) ref_alternate_in = ~ref_alternate_in;
  end
endmodule
`default_nettype wire

// ### test/selftrim_chk.sv
`timescale 1ns/1ps
`default_nettype none
module selftrim_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic trim_wr,
  input wire logic irq_clear,
  input wire logic [15:0] trim_reg,
  input wire logic [5:0] trim_value,
  input wire logic selftrim_irq_flag,
  input wire logic loop_active
);
  wire cond;
  assign cond = trim_reg[15] && loop_active &&
    ((trim_reg[10] ? trim_reg[11] : !trim_reg[11]) || (trim_reg[8] ? trim_reg[9] : !trim_reg[9]));
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence off_s;
    !trim_reg[15] [*3];
  endsequence
  reset_clear_a: assert property (disable iff (1'b0) rst |=> trim_reg == 16'h0000 && !loop_active)
    else $error("reset state wrong");
  idle_off_a: assert property (off_s |-> !loop_active)
    else $error("loop runs while disabled");
  enable_run_a: assert property ($rose(trim_reg[15]) |=> loop_active)
    else $error("loop not started");
  status_off_a: assert property (off_s |-> !trim_reg[11] && !trim_reg[9])
    else $error("status kept while disabled");
  trim_field_a: assert property (trim_reg[5:0] == trim_value)
    else $error("trim field differs from trim output");
  trim_step_a: assert property (trim_reg[15] && $past(trim_reg[15]) |->
    6'(trim_value - $past(trim_value)) inside {6'h00, 6'h01, 6'h3f})
    else $error("trim jumped while active");
  lock_range_a: assert property (trim_reg[9] |-> !trim_reg[11])
    else $error("lock and range fault together");
  irq_set_a: assert property ($rose(cond) |=> selftrim_irq_flag)
    else $error("flag not set");
  irq_cause_a: assert property ($rose(selftrim_irq_flag) |-> $past(cond))
    else $error("flag set without cause");
  irq_hold_a: assert property (selftrim_irq_flag && !irq_clear |=> selftrim_irq_flag)
    else $error("flag dropped");
endmodule
bind rc_oscillator_self_tune selftrim_chk chk_i (.clk(clk), .rst(rst), .trim_wr(trim_wr), .irq_clear(irq_clear),
  .trim_reg(trim_reg), .trim_value(trim_value), .selftrim_irq_flag(selftrim_irq_flag), .loop_active(loop_active));
`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_top;
  logic clk = 0;
  logic rst = 1;
  logic trim_wr = 0;
  logic irq_clear = 0;
  logic [15:0] trim_wdata = 16'h0000;
  wire logic rc_osc_in, ref_secondary_in, ref_alternate_in, selftrim_irq_flag, loop_active;
  wire logic [15:0] trim_reg;
  wire logic [5:0] trim_value;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  osc_model osc_model_i (.rc_osc_in(rc_osc_in), .ref_secondary_in(ref_secondary_in),
    .ref_alternate_in(ref_alternate_in));
  rc_oscillator_self_tune rc_oscillator_self_tune_i (.clk(clk), .rst(rst), .rc_osc_in(rc_osc_in),
    .ref_secondary_in(ref_secondary_in), .ref_alternate_in(ref_alternate_in), .trim_wr(trim_wr),
    .trim_wdata(trim_wdata), .irq_clear(irq_clear), .trim_reg(trim_reg), .trim_value(trim_value),
    .selftrim_irq_flag(selftrim_irq_flag), .loop_active(loop_active));
  task automatic wr(input logic [15:0] d);
    @(negedge clk);
    trim_wr = 1;
    trim_wdata = d;
    @(negedge clk);
    trim_wr = 0;
    @(negedge clk);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task t_reset;
    `CHK("trim_reg", 16'h0000, trim_reg)
    `CHK("loop_active", 1'b0, loop_active)
  endtask
  task t_enable;
    wr(16'h8505);
    `CHK("trim_reg", 16'h8505, trim_reg)
    @(negedge clk);
    `CHK("loop_active", 1'b1, loop_active)
  endtask
  task t_guard;
    wr(16'h853a);
    `CHK("trim_reg", 16'h8505, trim_reg)
    `CHK("trim_value", 6'h05, trim_value)
  endtask
  task automatic t_window;
    int i;
    for (i = 0; i < 60000 && selftrim_irq_flag !== 1'b1; i++) @(negedge clk);
    `CHK("flag", 1'b1, selftrim_irq_flag)
    `CHK("trim_reg", 16'h8d05, trim_reg)
    `CHK("trim_value", 6'h05, trim_value)
  endtask
  task t_clear;
    @(negedge clk);
    irq_clear = 1;
    @(negedge clk);
    irq_clear = 0;
    repeat (3) @(negedge clk);
    `CHK("flag", 1'b0, selftrim_irq_flag)
  endtask
  task t_disable;
    wr(16'h0000);
    repeat (2) @(negedge clk);
    `CHK("trim_reg", 16'h0005, trim_reg)
    `CHK("loop_active", 1'b0, loop_active)
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      mismatches++;
      wrap_up();
    end
  end
  initial begin
    repeat (4) @(negedge clk);
    rst = 0;
    t_reset();
    t_enable();
    t_guard();
    t_window();
    t_clear();
    t_disable();
    wrap_up();
  end
endmodule
`default_nettype wire
